/* rtl/fcc_top.sv */
// floating point ceiling conversion and control read unit with an AHB-Lite register port
// Notes on behaviour
// - ceil_to_long converts single or double to a signed 64-bit integer rounding up.
// - ceil_to_word converts to a signed 32-bit integer rounding up into the dest float_reg.
// - infinity, NaN or an out-of-range rounded value is invalid and sets the invalid flag.
// - with the invalid enable set the destination is left alone and the trap is taken.
// - with the invalid enable clear the largest positive value of the width is written.
// - conversions can raise invalid, unimplemented, inexact, unusable and reserved traps; here a conversion never traps as reserved, only the reserved op code does.
// - fp_control_read copies selector 0 or 31 whole into target_general_reg.
// - selector 25 returns condition bits 31..25 then bit 23 under 24 zero bits.
// - selector 26 returns cause bits at 17..12 and flag bits at 6..2, rest zero.
// - selector 28 returns enables at 11..7, bit 24 at bit 2 and rounding at 1..0.
// - fp_control_read traps only as unusable or reserved, never as arithmetic.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`include "fcc_map.svh"
`default_nettype none
module fcc_top #(
    parameter int NREG = 32,
    parameter logic [31:0] IMPL_VALUE = 32'h0000_0a5a // arbitrary implementation word
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output fcc_pkg::fcc_exc_t exc_code_o
);
    import fcc_pkg::*;

    fcc_cvt_if cif ();

    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;
    logic fp_en_r;
    logic [31:0] ctl_stat_r;
    logic [31:0] gpr_r;
    logic [4:0] fsel_r;
    fcc_exc_t exc_r;
    logic wrote_r;
    logic [63:0] freg_r [NREG];

    logic exec_w;
    fcc_op_t op_w;
    logic [4:0] src_w;
    logic [4:0] dst_w;
    logic [4:0] sel_w;
    logic is_cvt_w;
    logic trap_w;
    fcc_exc_t exc_nxt;
    logic wr_dst_w;
    logic [31:0] ctrl_val_w;
    logic [63:0] dst_val_w;

    // the size field is not decoded: only whole-word transfers reach this slave
    logic unused_w;
    assign unused_w = ^{hsize_i, haddr_i[31:8]};

    // address phase capture; reads get one wait state so they see every earlier write
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            if (hready_i && hsel_i && htrans_i[1]) begin
                wr_pend_r <= hwrite_i;
                rd_pend_r <= !hwrite_i;
                addr_r <= haddr_i[7:0];
            end
        end
    end

    assign hreadyout_o = !rd_pend_r;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_r;
    assign exc_code_o = exc_r;

    // read data mux; unmapped offsets answer zero
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            hrdata_r <= 32'h0;
        end else if (rd_pend_r) begin
            case (addr_r)
                `FCC_OFF_CTRL: hrdata_r <= {31'h0, fp_en_r};
                `FCC_OFF_CSR: hrdata_r <= ctl_stat_r;
                `FCC_OFF_IMPL: hrdata_r <= IMPL_VALUE;
                `FCC_OFF_STATUS: hrdata_r <= {29'h0, wrote_r, exc_r};
                `FCC_OFF_GPR: hrdata_r <= gpr_r;
                `FCC_OFF_FREG_SEL: hrdata_r <= {27'h0, fsel_r};
                `FCC_OFF_FREG_LO: hrdata_r <= freg_r[fsel_r][31:0];
                `FCC_OFF_FREG_HI: hrdata_r <= freg_r[fsel_r][63:32];
                default: hrdata_r <= 32'h0;
            endcase
        end
    end

    // command decode straight from the write data so the op completes with its data phase
    assign exec_w = wr_pend_r && (addr_r == `FCC_OFF_CMD);
    assign op_w = fcc_op_t'(hwdata_i[`FCC_CMD_OP +: 2]);
    assign src_w = hwdata_i[`FCC_CMD_SRC +: 5];
    assign dst_w = hwdata_i[`FCC_CMD_DST +: 5];
    assign sel_w = hwdata_i[`FCC_CMD_SEL +: 5];
    assign is_cvt_w = (op_w == FCC_OP_CEIL_WORD) || (op_w == FCC_OP_CEIL_LONG);
    assign dst_val_w = freg_r[dst_w];

    assign cif.src = freg_r[src_w];
    assign cif.is_double = hwdata_i[`FCC_CMD_FMT];
    assign cif.to_long = (op_w == FCC_OP_CEIL_LONG);

    fcc_ceil_cvt u_cvt (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .c(cif.cvt)
    );

    // enabled causes trap; unimplemented always traps
    assign trap_w = cif.unimpl || (cif.invalid && ctl_stat_r[`FCC_CSR_EN_V]) ||
                    (cif.inexact && ctl_stat_r[`FCC_CSR_EN_I]);

    // exception priority: unusable, then reserved, then arithmetic
    always_comb begin
        if (!fp_en_r) begin
            exc_nxt = FCC_EXC_CPU;
        end else if (op_w == FCC_OP_RSVD) begin
            exc_nxt = FCC_EXC_RI;
        end else if (is_cvt_w && trap_w) begin
            exc_nxt = FCC_EXC_FPE;
        end else begin
            exc_nxt = FCC_EXC_NONE;
        end
    end

    assign wr_dst_w = exec_w && is_cvt_w && (exc_nxt == FCC_EXC_NONE);

    // packed views of the control/status word; other selectors read as zero
    always_comb begin
        case (sel_w)
            `FCC_SEL_IMPL: ctrl_val_w = IMPL_VALUE;
            `FCC_SEL_CCR: ctrl_val_w = {24'h0, ctl_stat_r[31:25], ctl_stat_r[23]};
            `FCC_SEL_EXR: ctrl_val_w = {14'h0, ctl_stat_r[17:12], 5'h0, ctl_stat_r[6:2],
                                        2'h0};
            `FCC_SEL_ENR: ctrl_val_w = {20'h0, ctl_stat_r[11:7], 4'h0,
                                        ctl_stat_r[`FCC_CSR_FLUSH], ctl_stat_r[1:0]};
            `FCC_SEL_CSR: ctrl_val_w = ctl_stat_r;
            default: ctrl_val_w = 32'h0;
        endcase
    end

    // floating point access enable
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fp_en_r <= 1'b0;
        end else if (wr_pend_r && addr_r == `FCC_OFF_CTRL) begin
            fp_en_r <= hwdata_i[`FCC_CTRL_FP_EN];
        end
    end

    // control/status: a conversion rewrites the causes and accumulates the flags
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctl_stat_r <= `FCC_CSR_RST;
        end else if (wr_pend_r && addr_r == `FCC_OFF_CSR) begin
            ctl_stat_r <= hwdata_i;
        end else if (exec_w && is_cvt_w && fp_en_r) begin
            ctl_stat_r[`FCC_CSR_CAUSE_E] <= cif.unimpl;
            ctl_stat_r[`FCC_CSR_CAUSE_V] <= cif.invalid;
            ctl_stat_r[`FCC_CSR_CAUSE_I] <= cif.inexact;
            ctl_stat_r[15:13] <= 3'h0;
            if (cif.invalid) begin
                ctl_stat_r[`FCC_CSR_FLAG_V] <= 1'b1;
            end
            if (cif.inexact) begin
                ctl_stat_r[`FCC_CSR_FLAG_I] <= 1'b1;
            end
        end
    end

    // target_general_reg, loaded only by fp_control_read
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            gpr_r <= 32'h0;
        end else if (exec_w && op_w == FCC_OP_CTRL_READ && fp_en_r) begin
            gpr_r <= ctrl_val_w;
        end
    end

    // outcome of the last command
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            exc_r <= FCC_EXC_NONE;
            wrote_r <= 1'b0;
        end else if (exec_w) begin
            exc_r <= exc_nxt;
            wrote_r <= wr_dst_w;
        end
    end

    // window select for bus access to the float registers
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fsel_r <= 5'h0;
        end else if (wr_pend_r && addr_r == `FCC_OFF_FREG_SEL) begin
            fsel_r <= hwdata_i[4:0];
        end
    end

    // float register file; a word result leaves the upper half untouched
    for (genvar i = 0; i < NREG; i++) begin : g_freg
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                freg_r[i] <= 64'h0;
            end else if (wr_pend_r && addr_r == `FCC_OFF_FREG_LO && fsel_r == 5'(i)) begin
                freg_r[i][31:0] <= hwdata_i;
            end else if (wr_pend_r && addr_r == `FCC_OFF_FREG_HI && fsel_r == 5'(i)) begin
                freg_r[i][63:32] <= hwdata_i;
            end else if (wr_dst_w && dst_w == 5'(i)) begin
                if (op_w == FCC_OP_CEIL_LONG) begin
                    freg_r[i] <= cif.result;
                end else begin
                    freg_r[i][31:0] <= cif.result[31:0];
                end
            end
        end
    end

    trap_nowrite_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_w && is_cvt_w && fp_en_r && cif.invalid && ctl_stat_r[`FCC_CSR_EN_V])
        |=> (freg_r[$past(dst_w)] == $past(dst_val_w)) && (exc_r == FCC_EXC_FPE))
        else $error("destination written or no trap on enabled invalid");

    inv_flag_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_w && is_cvt_w && fp_en_r && cif.invalid)
        |=> ctl_stat_r[`FCC_CSR_FLAG_V] && ctl_stat_r[`FCC_CSR_CAUSE_V])
        else $error("invalid flag or cause not set");

    word_default_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_dst_w && op_w == FCC_OP_CEIL_WORD && cif.invalid)
        |=> (freg_r[$past(dst_w)][31:0] == 32'h7fff_ffff) && wrote_r)
        else $error("word default result not written");

    sel_ccr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_w && fp_en_r && op_w == FCC_OP_CTRL_READ && sel_w == `FCC_SEL_CCR)
        |=> gpr_r == {24'h0, $past(ctl_stat_r[31:25]), $past(ctl_stat_r[23])})
        else $error("selector 25 view wrong");

    sel_exr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_w && fp_en_r && op_w == FCC_OP_CTRL_READ && sel_w == `FCC_SEL_EXR)
        |=> (gpr_r[17:12] == $past(ctl_stat_r[17:12]))
            && (gpr_r[6:2] == $past(ctl_stat_r[6:2]))
            && (gpr_r[31:18] == 14'h0) && (gpr_r[11:7] == 5'h0) && (gpr_r[1:0] == 2'h0))
        else $error("selector 26 view wrong");

    ctrl_nofp_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_w && op_w == FCC_OP_CTRL_READ) |=> $stable(ctl_stat_r) && (exc_r != FCC_EXC_FPE))
        else $error("control read touched arithmetic state");

    unusable_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_w && !fp_en_r) |=> (exc_r == FCC_EXC_CPU) && $stable(gpr_r) && !wrote_r)
        else $error("disabled access not trapped as unusable");

    rd_wait_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (hready_i && hsel_i && htrans_i[1] && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read not answered after exactly one wait state");
endmodule : fcc_top
`default_nettype wire

/* common/fcc_map.svh */
// register offsets, field positions and constants of the ceiling converter block
`ifndef FCC_MAP_SVH
`define FCC_MAP_SVH

// byte offsets inside the block's 256-byte window
`define FCC_OFF_CTRL 8'h00
`define FCC_OFF_CSR 8'h04
`define FCC_OFF_IMPL 8'h08
`define FCC_OFF_CMD 8'h0c
`define FCC_OFF_STATUS 8'h10
`define FCC_OFF_GPR 8'h14
`define FCC_OFF_FREG_SEL 8'h18
`define FCC_OFF_FREG_LO 8'h1c
`define FCC_OFF_FREG_HI 8'h20

// control register: floating point access enable
`define FCC_CTRL_FP_EN 0

// command word fields (lsb positions, selectors are 5 bits)
`define FCC_CMD_OP 0
`define FCC_CMD_FMT 2
`define FCC_CMD_SRC 4
`define FCC_CMD_DST 9
`define FCC_CMD_SEL 14

// status word fields
`define FCC_STAT_EXC 0
`define FCC_STAT_WROTE 2

// control/status field positions
`define FCC_CSR_FLAG_I 2
`define FCC_CSR_FLAG_V 6
`define FCC_CSR_EN_I 7
`define FCC_CSR_EN_V 11
`define FCC_CSR_CAUSE_I 12
`define FCC_CSR_CAUSE_V 16
`define FCC_CSR_CAUSE_E 17
`define FCC_CSR_FLUSH 24
`define FCC_CSR_RST 32'h0000_0000

// control register selectors
`define FCC_SEL_IMPL 5'h00
`define FCC_SEL_CCR 5'h19
`define FCC_SEL_EXR 5'h1a
`define FCC_SEL_ENR 5'h1c
`define FCC_SEL_CSR 5'h1f

// signed target bounds, as magnitudes
`define FCC_MAX_L 64'h7fff_ffff_ffff_ffff
`define FCC_MAX_W 64'h0000_0000_7fff_ffff
`define FCC_NEG_L 64'h8000_0000_0000_0000
`define FCC_NEG_W 64'h0000_0000_8000_0000

`endif

/* common/fcc_pkg.sv */
// types shared by the ceiling converter block
`default_nettype none
package fcc_pkg;
    typedef enum logic [1:0] {
        FCC_OP_CTRL_READ,
        FCC_OP_CEIL_WORD,
        FCC_OP_CEIL_LONG,
        FCC_OP_RSVD
    } fcc_op_t;
    typedef enum logic [1:0] {
        FCC_EXC_NONE,
        FCC_EXC_CPU,
        FCC_EXC_RI,
        FCC_EXC_FPE
    } fcc_exc_t;
endpackage : fcc_pkg
`default_nettype wire

/* common/fcc_cvt_if.sv */
// operand and result bundle between the issue logic and the ceiling converter
`default_nettype none
interface fcc_cvt_if;
    logic [63:0] src;
    logic is_double;
    logic to_long;
    logic [63:0] result;
    logic invalid;
    logic inexact;
    logic unimpl;
    modport issue (output src, output is_double, output to_long,
                   input result, input invalid, input inexact, input unimpl);
    modport cvt (input src, input is_double, input to_long,
                 output result, output invalid, output inexact, output unimpl);
endinterface : fcc_cvt_if
`default_nettype wire

/* rtl/fcc_ceil_cvt.sv */
// combinational ceiling conversion of single or double to 32 or 64 bit integer
`include "fcc_map.svh"
`default_nettype none
module fcc_ceil_cvt (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    fcc_cvt_if.cvt c
);
    import fcc_pkg::*;

    logic sgn;
    logic [10:0] exp;
    logic [51:0] frac;
    logic nan_inf;
    logic [63:0] mag;
    logic big;
    logic sticky;
    logic [63:0] lim_pos;
    logic [63:0] lim_neg;

    // unpack; singles are rebased onto the double layout so one shifter serves both
    always_comb begin
        if (c.is_double) begin
            sgn = c.src[63];
            exp = c.src[62:52];
            frac = c.src[51:0];
        end else begin
            sgn = c.src[31];
            frac = {c.src[22:0], 29'h0};
            if (c.src[30:23] == 8'hff) begin
                exp = 11'h7ff;
            end else if (c.src[30:23] == 8'h00) begin
                exp = 11'h000;
            end else begin
                exp = {3'h0, c.src[30:23]} + 11'h380;
            end
        end
        nan_inf = (exp == 11'h7ff);
        // denormal operands are handed to software
        c.unimpl = (exp == 11'h000) && (frac != 52'h0);
    end

    // align the significand; rounding always toward plus infinity, mode register ignored
    always_comb begin
        logic signed [12:0] e;
        logic [12:0] r;
        logic [63:0] m;
        e = 13'sh0;
        r = 13'h0;
        m = {11'h0, 1'b1, frac};
        mag = 64'h0;
        big = 1'b0;
        sticky = 1'b0;
        e = $signed({2'b00, exp}) - 13'sd1075;
        if (exp == 11'h000) begin
            sticky = 1'b0;
        end else if (e >= 0) begin
            big = (e > 13'sd11);
            mag = m << e[3:0];
        end else begin
            r = 13'(-e);
            if (r > 13'd63) begin
                sticky = 1'b1;
            end else begin
                mag = m >> r[5:0];
                sticky = |(m & ((64'h1 << r[5:0]) - 64'h1));
            end
            if (!sgn && sticky) begin
                mag = mag + 64'h1;
            end
        end
    end

    // range check after rounding against the chosen target width
    always_comb begin
        lim_pos = c.to_long ? `FCC_MAX_L : `FCC_MAX_W;
        lim_neg = c.to_long ? `FCC_NEG_L : `FCC_NEG_W;
        c.invalid = !c.unimpl && (nan_inf || big ||
                    (sgn ? (mag > lim_neg) : (mag > lim_pos)));
        c.inexact = sticky && !c.invalid && !c.unimpl;
        if (c.invalid) begin
            c.result = lim_pos;
        end else if (sgn) begin
            c.result = 64'h0 - mag;
        end else begin
            c.result = mag;
        end
    end

    inv_default_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        c.invalid |-> (c.result == (c.to_long ? `FCC_MAX_L : `FCC_MAX_W)))
        else $error("invalid conversion without largest positive default");

    ceil_up_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (c.inexact && !sgn) |-> (c.result != 64'h0) && !c.result[63])
        else $error("positive fraction not rounded up");

    word_range_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!c.invalid && !c.to_long) |-> (c.result[63:31] == {33{c.result[31]}}))
        else $error("word result outside signed 32-bit range");
endmodule : fcc_ceil_cvt
`default_nettype wire

/* verif/fcc_host_model.sv */
// bus master standing in for the host core that issues commands to the unit
`include "fcc_map.svh"
`default_nettype none
module fcc_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rdy_s;
    logic [31:0] rd_s;
    // sample on the falling edge, half a cycle before the rising edge, so that edge's own updates cannot race the read
    always @(negedge clk_i) begin
        rdy_s = hready_i;
        rd_s = hrdata_i;
    end
    // bus idle at time zero
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'b010;
        hwdata_o = 32'h0;
    end
    // one single word transfer; entered right after a rising edge
    task xfer(input logic wr, input logic [7:0] o, input logic [31:0] d, output logic [31:0] q);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, o};
        htrans_o <= 2'b10;
        hwrite_o <= wr;
        do @(posedge clk_i); while (rdy_s !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= wr ? d : ~d;
        do @(posedge clk_i); while (rdy_s !== 1'b1);
        q = rd_s;
        // released data lines do not keep the last value
        hwdata_o <= ~d;
    endtask : xfer
    // commands name valid float registers and existing selectors only
    // the 64-bit form is issued only while the full register file is in use
    task issue(input logic [1:0] op, input logic fmt, input logic [4:0] src,
        input logic [4:0] dst, input logic [4:0] sel);
        logic [31:0] q;
        xfer(1'b1, `FCC_OFF_CMD, {13'h0, sel, dst, src, 1'b0, fmt, op}, q);
    endtask : issue
endmodule : fcc_host_model
`default_nettype wire

/* verif/fcc_top_test.sv */
// self-checking bench for the ceiling conversion and control read unit
`include "fcc_map.svh"
`default_nettype none
module fcc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fcc_pkg::*;
    localparam logic [31:0] IMPL_T = 32'h0000_3c96; // arbitrary implementation word
    localparam logic [31:0] CSR_X = 32'hb6c3_5e9d;
    localparam logic [63:0] PRE = 64'h1357_9bdf_2468_ace0;
    localparam logic [4:0] SELS [5] = '{`FCC_SEL_IMPL, `FCC_SEL_CCR, `FCC_SEL_EXR,
        `FCC_SEL_ENR, `FCC_SEL_CSR};
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    fcc_exc_t exc;
    int mismatches = 0;
    int tests_run = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    fcc_top #(.NREG(32), .IMPL_VALUE(IMPL_T)) i_fcc_top (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .exc_code_o(exc));
    fcc_host_model i_fcc_host_model (.clk_i(ref_clk_i), .hready_i(hready),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
    // verdict in one place, used by the main sequence and the watchdog
    task finish_test();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] q;
        i_fcc_host_model.xfer(1'b1, o, d, q);
    endtask : wr
    task rd(input logic [7:0] o, output logic [31:0] q);
        i_fcc_host_model.xfer(1'b0, o, 32'h0, q);
    endtask : rd
    task rdc(input string nm, input logic [7:0] o, input logic [31:0] e);
        logic [31:0] q;
        rd(o, q);
        chk(nm, 64'(e), 64'(q));
        chk("hresp", 64'h0, 64'(hresp));
    endtask : rdc
    // issue a command and look at the outcome code once the data edge has landed
    task cmd(input logic [1:0] op, input logic fmt, input logic [4:0] sel, input fcc_exc_t code);
        i_fcc_host_model.issue(op, fmt, 5'd3, 5'd7, sel);
        @(negedge ref_clk_i);
        chk("exc code", 64'(code), 64'(exc));
        @(posedge ref_clk_i);
    endtask : cmd
    task setf(input logic [4:0] idx, input logic [63:0] v);
        wr(`FCC_OFF_FREG_SEL, {27'h0, idx});
        wr(`FCC_OFF_FREG_LO, v[31:0]);
        wr(`FCC_OFF_FREG_HI, v[63:32]);
    endtask : setf
    // packed views of the control/status word as software sees them
    function automatic logic [31:0] view(input logic [4:0] s, input logic [31:0] x);
        case (s)
            5'h00: view = IMPL_T;
            5'h19: view = {24'h0, x[31:25], x[23]};
            5'h1a: view = {14'h0, x[17:12], 5'h0, x[6:2], 2'h0};
            5'h1c: view = {20'h0, x[11:7], 4'h0, x[24], x[1:0]};
            default: view = x;
        endcase
    endfunction : view
    // one conversion: rm is deliberately not toward +inf in most rows; m masks ambiguous causes
    task cvt(input logic [1:0] rm, input logic fmt, input logic lng, input logic [63:0] src,
        input logic [63:0] res, input logic [5:0] cs, input logic [5:0] m, input logic [4:0] en,
        input fcc_exc_t code);
        logic [31:0] q;
        logic [63:0] e;
        wr(`FCC_OFF_CSR, {20'h0, en, 5'h0, rm});
        setf(5'd3, src);
        setf(5'd7, PRE);
        cmd(lng ? FCC_OP_CEIL_LONG : FCC_OP_CEIL_WORD, fmt, 5'd0, code);
        e = (code != FCC_EXC_NONE) ? PRE : lng ? res : {PRE[63:32], res[31:0]};
        rdc("dest lo", `FCC_OFF_FREG_LO, e[31:0]);
        rdc("dest hi", `FCC_OFF_FREG_HI, e[63:32]);
        rd(`FCC_OFF_CSR, q);
        chk("cause", 64'(cs & m), 64'(q[17:12] & m));
        chk("flags", 64'(cs[4:0] & m[4:0]), 64'(q[6:2] & m[4:0]));
        rd(`FCC_OFF_STATUS, q);
        chk("dest written", 64'(code == FCC_EXC_NONE), 64'(q[2]));
    endtask : cvt
    // hang guard, far above the roughly 450 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdc("ctrl", `FCC_OFF_CTRL, 32'h0);
        rdc("csr", `FCC_OFF_CSR, `FCC_CSR_RST);
        rdc("status", `FCC_OFF_STATUS, 32'h0);
        rdc("impl", `FCC_OFF_IMPL, IMPL_T);
        wr(8'h40, 32'hffff_ffff);
        rdc("unmapped", 8'h40, 32'h0);
        // with access disabled every command reports unusable
        cmd(FCC_OP_CEIL_WORD, 1'b0, 5'd0, FCC_EXC_CPU);
        cmd(FCC_OP_CTRL_READ, 1'b0, `FCC_SEL_CSR, FCC_EXC_CPU);
        wr(`FCC_OFF_CTRL, 32'h1);
        cmd(FCC_OP_RSVD, 1'b0, 5'd0, FCC_EXC_RI);
        wr(`FCC_OFF_CSR, CSR_X);
        foreach (SELS[i]) begin
            cmd(FCC_OP_CTRL_READ, 1'b0, SELS[i], FCC_EXC_NONE);
            rdc("gpr view", `FCC_OFF_GPR, view(SELS[i], CSR_X));
        end
        rdc("csr kept", `FCC_OFF_CSR, CSR_X);
        cvt(1, 0, 0, 64'h3fc0_0000, 64'h2, 6'h01, 6'h3f, 0, FCC_EXC_NONE);
        cvt(3, 0, 0, 64'hbfc0_0000, 64'hffff_ffff, 6'h01, 6'h3f, 0, FCC_EXC_NONE);
        cvt(0, 1, 1, 64'h4000_0000_0000_0000, 64'h2, 6'h00, 6'h3f, 0, FCC_EXC_NONE);
        cvt(3, 1, 1, 64'hc004_0000_0000_0000, 64'hffff_ffff_ffff_fffe, 6'h01, 6'h3f, 0,
            FCC_EXC_NONE);
        cvt(0, 0, 0, 64'h7f80_0000, 64'h7fff_ffff, 6'h10, 6'h3f, 0, FCC_EXC_NONE);
        cvt(0, 1, 1, 64'h7ff8_0000_0000_0000, 64'h7fff_ffff_ffff_ffff, 6'h10, 6'h3f, 0,
            FCC_EXC_NONE);
        cvt(1, 1, 0, 64'h41df_ffff_ffe0_0000, 64'h7fff_ffff, 6'h10, 6'h30, 0, FCC_EXC_NONE);
        cvt(2, 1, 0, 64'hc1e0_0000_0000_0000, 64'h8000_0000, 6'h00, 6'h3f, 0, FCC_EXC_NONE);
        cvt(1, 1, 1, 64'h43e0_0000_0000_0000, 64'h7fff_ffff_ffff_ffff, 6'h10, 6'h3f, 0,
            FCC_EXC_NONE);
        cvt(1, 1, 1, 64'hc3e0_0000_0000_0000, 64'h8000_0000_0000_0000, 6'h00, 6'h3f, 0,
            FCC_EXC_NONE);
        cvt(0, 0, 0, 64'h7f80_0000, 64'h0, 6'h10, 6'h3f, 5'h10, FCC_EXC_FPE);
        cvt(0, 0, 1, 64'h3fc0_0000, 64'h0, 6'h01, 6'h3f, 5'h01, FCC_EXC_FPE);
        cvt(0, 0, 0, 64'h0000_0001, 64'h0, 6'h20, 6'h20, 0, FCC_EXC_FPE);
        finish_test();
    end
endmodule : fcc_top_test
`default_nettype wire
